//--- rtl/p9fs_pkg.sv
// Contract
// - Direction bit 1 with no alternate select: pin driven as port output
// - Direction 0, pull-up 1, no alternates: port input with pull-up on
// - Direction 0, pull-up 0, no alternates: plain port input, no pull-up
// - A-D bit 6 set, bit 7 clear, serial select 0: extension input
// - A-D bits 7 and 6 set, serial select 0: op-amp output on pin
// - Serial select bit set, other selects clear: pin is serial clock
// - Serial clock direction bit: 1 drives clock out, 0 takes it in
// - D-A enable bit, with the timer event clock bit clear, puts channel output on its pin
// - All selects clear: pins feed timer B4 and B3 count inputs
package p9fs_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [9:0] DIR_IDX = 10'h3F3;
    localparam logic [9:0] PU_IDX = 10'h3FE;
    localparam logic [9:0] AD1_IDX = 10'h3D7;
    localparam logic [9:0] SIO4_IDX = 10'h366;
    localparam logic [9:0] DAC_IDX = 10'h3DC;
    localparam logic [9:0] TB4_IDX = 10'h35C;
    localparam logic [9:0] TB3_IDX = 10'h35B;
    localparam logic [9:0] DATA_IDX = 10'h310;
    localparam logic [9:0] STAT_IDX = 10'h311;

    localparam int DIR_PIN5_BIT = 5;
    localparam int DIR_PIN4_BIT = 4;
    localparam int DIR_PIN3_BIT = 3;
    localparam int PU_HI_BIT = 3;
    localparam int PU_LO_BIT = 2;
    localparam int AD_EXT_BIT = 6;
    localparam int AD_OPAMP_BIT = 7;
    localparam int SIO_PSEL_BIT = 3;
    localparam int SIO_CLKDIR_BIT = 6;
    localparam int DA1_EN_BIT = 1;
    localparam int DA0_EN_BIT = 0;
    localparam int EVT_CLK_BIT = 7;

    // Status register layout
    localparam int ST_IN3_BIT = 0;
    localparam int ST_IN4_BIT = 1;
    localparam int ST_IN5_BIT = 2;
    localparam int ST_OE3_BIT = 3;
    localparam int ST_OE4_BIT = 4;
    localparam int ST_OE5_BIT = 5;

    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] PU_RST = 8'h00;
    localparam logic [7:0] AD1_RST = 8'h00;
    localparam logic [7:0] SIO4_RST = 8'h00;
    localparam logic [7:0] DAC_RST = 8'h00;
    localparam logic [7:0] TB_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [8:0] {
        PM_PORT_IN    = 9'h001,
        PM_PORT_IN_PU = 9'h002,
        PM_PORT_OUT   = 9'h004,
        PM_ANA_IN     = 9'h008,
        PM_OPAMP_OUT  = 9'h010,
        PM_SCLK_OUT   = 9'h020,
        PM_SCLK_IN    = 9'h040,
        PM_DA_OUT     = 9'h080,
        PM_CNT_IN     = 9'h100
    } p9fs_mode_t;
endpackage

//--- rtl/p9fs_sync.sv
`timescale 1ns/1ps
module p9fs_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin_raw,
    output logic [WIDTH-1:0] level
);
    generate
        if (WIDTH < 1) begin : g_bad
            $error("p9fs_sync: WIDTH must be at least 1");
        end
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic lv;
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    lv <= 1'b0;
                end else if (ce) begin
                    s1 <= pin_raw[i];
                    s2 <= s1;
                    s3 <= s2;
                    // Accept a change only once two stages agree
                    if (s2 == s3) begin
                        lv <= s3;
                    end
                end
            end
            assign level[i] = lv;
        end
    endgenerate
endmodule // p9fs_sync

//--- rtl/p9fs_pin_select.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module p9fs_pin_select #(
    parameter int ADDR_W = p9fs_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port9_bit5_in,
    output logic port9_bit5_out,
    output logic port9_bit5_oe,
    output logic port9_bit5_pullup,
    input wire logic port9_bit4_in,
    output logic port9_bit4_out,
    output logic port9_bit4_oe,
    output logic port9_bit4_pullup,
    input wire logic port9_bit3_in,
    output logic port9_bit3_out,
    output logic port9_bit3_oe,
    output logic port9_bit3_pullup,
    input wire logic serial_unit4_clock_drive,
    output logic serial_unit4_clock,
    output logic analog_extension_in0_sel,
    output logic opamp_out_en,
    output logic analog_out_ch1_en,
    output logic analog_out_ch0_en,
    output logic timer_b4_count_in,
    output logic timer_b3_count_in
);
    generate
        if (ADDR_W < p9fs_pkg::ADDR_W) begin : g_bad
            $error("p9fs_pin_select: ADDR_W too small for the map");
        end
    endgenerate

    logic [7:0] port9_direction;
    logic [7:0] port_pullup_control;
    logic [7:0] ad_control1;
    logic [7:0] serial4_control;
    logic [7:0] da_control;
    logic [7:0] timer_b4_mode;
    logic [7:0] timer_b3_mode;
    logic [7:0] port9_data;
    logic [2:0] pin_level;
    p9fs_pkg::p9fs_mode_t mode5;
    p9fs_pkg::p9fs_mode_t mode4;
    p9fs_pkg::p9fs_mode_t mode3;

    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx == p9fs_pkg::DIR_IDX) || (idx == p9fs_pkg::PU_IDX)
            || (idx == p9fs_pkg::AD1_IDX) || (idx == p9fs_pkg::SIO4_IDX)
            || (idx == p9fs_pkg::DAC_IDX) || (idx == p9fs_pkg::TB4_IDX)
            || (idx == p9fs_pkg::TB3_IDX) || (idx == p9fs_pkg::DATA_IDX)
            || (idx == p9fs_pkg::STAT_IDX);
    endfunction

    // Shared pin: direction wins, then pull-up, then alternates
    function automatic p9fs_pkg::p9fs_mode_t decode_pin5(input logic dir,
        input logic pu, input logic ad7, input logic ad6, input logic psel,
        input logic clkdir);
        if (dir) begin
            decode_pin5 = p9fs_pkg::PM_PORT_OUT;
        end else if (pu) begin
            decode_pin5 = p9fs_pkg::PM_PORT_IN_PU;
        end else if (!psel && ad6 && !ad7) begin
            decode_pin5 = p9fs_pkg::PM_ANA_IN;
        end else if (!psel && ad6 && ad7) begin
            decode_pin5 = p9fs_pkg::PM_OPAMP_OUT;
        end else if (psel && !ad6 && !ad7) begin
            decode_pin5 = clkdir ? p9fs_pkg::PM_SCLK_OUT
                                 : p9fs_pkg::PM_SCLK_IN;
        end else begin
            decode_pin5 = p9fs_pkg::PM_PORT_IN;
        end
    endfunction

    function automatic p9fs_pkg::p9fs_mode_t decode_da(input logic dir,
        input logic pu, input logic da_en, input logic evt);
        if (dir) begin
            decode_da = p9fs_pkg::PM_PORT_OUT;
        end else if (pu) begin
            decode_da = p9fs_pkg::PM_PORT_IN_PU;
        end else if (da_en && !evt) begin
            decode_da = p9fs_pkg::PM_DA_OUT;
        end else if (!da_en && !evt) begin
            decode_da = p9fs_pkg::PM_CNT_IN;
        end else begin
            decode_da = p9fs_pkg::PM_PORT_IN;
        end
    endfunction

    // AXI4-Lite write channel
    logic aw_held;
    logic w_held;
    logic [9:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [9:0] wr_idx;
    logic [7:0] wr_byte;
    logic wr_lane;

    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = ce && !s_axi_bvalid && (aw_held || aw_take)
        && (w_held || w_take);
    assign wr_idx = aw_held ? aw_idx : s_axi_awaddr[11:2];
    assign wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
    assign wr_lane = w_held ? w_lane : s_axi_wstrb[0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 10'h000;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= p9fs_pkg::RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= idx_mapped(wr_idx) ? p9fs_pkg::RESP_OKAY
                                                  : p9fs_pkg::RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                    aw_idx <= s_axi_awaddr[11:2];
                end
                if (w_take) begin
                    w_held <= 1'b1;
                    w_byte <= s_axi_wdata[7:0];
                    w_lane <= s_axi_wstrb[0];
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port9_direction <= p9fs_pkg::DIR_RST;
            port_pullup_control <= p9fs_pkg::PU_RST;
            ad_control1 <= p9fs_pkg::AD1_RST;
            serial4_control <= p9fs_pkg::SIO4_RST;
            da_control <= p9fs_pkg::DAC_RST;
            timer_b4_mode <= p9fs_pkg::TB_RST;
            timer_b3_mode <= p9fs_pkg::TB_RST;
            port9_data <= p9fs_pkg::DATA_RST;
        end else if (ce && do_write && wr_lane) begin
            unique case (wr_idx)
                p9fs_pkg::DIR_IDX: port9_direction <= wr_byte;
                p9fs_pkg::PU_IDX: port_pullup_control <= wr_byte;
                p9fs_pkg::AD1_IDX: ad_control1 <= wr_byte;
                p9fs_pkg::SIO4_IDX: serial4_control <= wr_byte;
                p9fs_pkg::DAC_IDX: da_control <= wr_byte;
                p9fs_pkg::TB4_IDX: timer_b4_mode <= wr_byte;
                p9fs_pkg::TB3_IDX: timer_b3_mode <= wr_byte;
                p9fs_pkg::DATA_IDX: port9_data <= wr_byte;
                default: ;
            endcase
        end
    end

    // AXI4-Lite read channel
    logic [9:0] rd_idx;
    logic [7:0] rd_value;
    logic [7:0] status;

    assign s_axi_arready = ce && !s_axi_rvalid;
    assign rd_idx = s_axi_araddr[11:2];

    always_comb begin
        status = 8'h00;
        status[p9fs_pkg::ST_IN3_BIT] = pin_level[0];
        status[p9fs_pkg::ST_IN4_BIT] = pin_level[1];
        status[p9fs_pkg::ST_IN5_BIT] = pin_level[2];
        status[p9fs_pkg::ST_OE3_BIT] = port9_bit3_oe;
        status[p9fs_pkg::ST_OE4_BIT] = port9_bit4_oe;
        status[p9fs_pkg::ST_OE5_BIT] = port9_bit5_oe;
    end

    always_comb begin
        unique case (rd_idx)
            p9fs_pkg::DIR_IDX: rd_value = port9_direction;
            p9fs_pkg::PU_IDX: rd_value = port_pullup_control;
            p9fs_pkg::AD1_IDX: rd_value = ad_control1;
            p9fs_pkg::SIO4_IDX: rd_value = serial4_control;
            p9fs_pkg::DAC_IDX: rd_value = da_control;
            p9fs_pkg::TB4_IDX: rd_value = timer_b4_mode;
            p9fs_pkg::TB3_IDX: rd_value = timer_b3_mode;
            p9fs_pkg::DATA_IDX: rd_value = port9_data;
            p9fs_pkg::STAT_IDX: rd_value = status;
            default: rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= p9fs_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_value};
                s_axi_rresp <= idx_mapped(rd_idx) ? p9fs_pkg::RESP_OKAY
                                                  : p9fs_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pin inputs into the clock domain
    p9fs_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .pin_raw({port9_bit5_in, port9_bit4_in, port9_bit3_in}),
        .level(pin_level)
    );

    assign mode5 = decode_pin5(port9_direction[p9fs_pkg::DIR_PIN5_BIT],
        port_pullup_control[p9fs_pkg::PU_HI_BIT],
        ad_control1[p9fs_pkg::AD_OPAMP_BIT], ad_control1[p9fs_pkg::AD_EXT_BIT],
        serial4_control[p9fs_pkg::SIO_PSEL_BIT],
        serial4_control[p9fs_pkg::SIO_CLKDIR_BIT]);
    assign mode4 = decode_da(port9_direction[p9fs_pkg::DIR_PIN4_BIT],
        port_pullup_control[p9fs_pkg::PU_HI_BIT],
        da_control[p9fs_pkg::DA1_EN_BIT],
        timer_b4_mode[p9fs_pkg::EVT_CLK_BIT]);
    assign mode3 = decode_da(port9_direction[p9fs_pkg::DIR_PIN3_BIT],
        port_pullup_control[p9fs_pkg::PU_LO_BIT],
        da_control[p9fs_pkg::DA0_EN_BIT],
        timer_b3_mode[p9fs_pkg::EVT_CLK_BIT]);

    assign port9_bit5_oe = (mode5 == p9fs_pkg::PM_PORT_OUT)
        || (mode5 == p9fs_pkg::PM_SCLK_OUT);
    assign port9_bit4_oe = (mode4 == p9fs_pkg::PM_PORT_OUT);
    assign port9_bit3_oe = (mode3 == p9fs_pkg::PM_PORT_OUT);
    // pull-ups by nibble, only in pulled input
    assign port9_bit5_pullup = (mode5 == p9fs_pkg::PM_PORT_IN_PU);
    assign port9_bit4_pullup = (mode4 == p9fs_pkg::PM_PORT_IN_PU);
    assign port9_bit3_pullup = (mode3 == p9fs_pkg::PM_PORT_IN_PU);
    assign analog_extension_in0_sel = (mode5 == p9fs_pkg::PM_ANA_IN);
    assign opamp_out_en = (mode5 == p9fs_pkg::PM_OPAMP_OUT);
    assign analog_out_ch1_en = (mode4 == p9fs_pkg::PM_DA_OUT);
    assign analog_out_ch0_en = (mode3 == p9fs_pkg::PM_DA_OUT);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port9_bit5_out <= 1'b0;
            port9_bit4_out <= 1'b0;
            port9_bit3_out <= 1'b0;
            serial_unit4_clock <= 1'b0;
            timer_b4_count_in <= 1'b0;
            timer_b3_count_in <= 1'b0;
        end else if (ce) begin
            port9_bit5_out <= (mode5 == p9fs_pkg::PM_SCLK_OUT)
                ? serial_unit4_clock_drive
                : port9_data[p9fs_pkg::DIR_PIN5_BIT];
            port9_bit4_out <= port9_data[p9fs_pkg::DIR_PIN4_BIT];
            port9_bit3_out <= port9_data[p9fs_pkg::DIR_PIN3_BIT];
            serial_unit4_clock <= (mode5 == p9fs_pkg::PM_SCLK_IN)
                ? pin_level[2] : 1'b0;
            timer_b4_count_in <= (mode4 == p9fs_pkg::PM_CNT_IN)
                ? pin_level[1] : 1'b0;
            timer_b3_count_in <= (mode3 == p9fs_pkg::PM_CNT_IN)
                ? pin_level[0] : 1'b0;
        end
    end

    chk_port_out: assert property (@(posedge clk) disable iff (!reset_n)
        port9_direction[5] |-> port9_bit5_oe && !port9_bit5_pullup
            && !opamp_out_en)
        else $error("port output mode not driving pin");
    chk_pulled_in: assert property (@(posedge clk)
        disable iff (!reset_n)
        !port9_direction[4] && port_pullup_control[3]
            |-> port9_bit4_pullup && !port9_bit4_oe && !analog_out_ch1_en)
        else $error("pulled input mode wrong");
    chk_plain_in: assert property (@(posedge clk) disable iff (!reset_n)
        (port9_direction[3:2] == 2'h0) && (port_pullup_control[2] == 1'b0)
            |-> !port9_bit3_pullup && !port9_bit3_oe)
        else $error("plain input has drive or pull-up");
    chk_ana_in: assert property (@(posedge clk) disable iff (!reset_n)
        (mode5 != p9fs_pkg::PM_PORT_OUT) && !port9_bit5_pullup
            && ad_control1[6] && !ad_control1[7] && !serial4_control[3]
            |-> analog_extension_in0_sel && !port9_bit5_oe)
        else $error("extension input not selected");
    chk_opamp: assert property (@(posedge clk) disable iff (!reset_n)
        opamp_out_en |-> ad_control1[7] && ad_control1[6]
            && !serial4_control[3] && !port9_direction[5])
        else $error("op-amp output without its selects");
    chk_sclk_in: assert property (@(posedge clk) disable iff (!reset_n)
        ce && (mode5 == p9fs_pkg::PM_SCLK_IN)
            |=> serial_unit4_clock == $past(pin_level[2]))
        else $error("serial clock input not passed to unit");
    chk_sclk_dir: assert property (@(posedge clk) disable iff (!reset_n)
        ce && serial4_control[3] && (ad_control1[7:6] == 2'h0)
            && !port9_direction[5] && !port_pullup_control[3]
            |-> (port9_bit5_oe == serial4_control[6])
                ##1 (!$past(serial4_control[6])
                    || port9_bit5_out == $past(serial_unit4_clock_drive)))
        else $error("serial clock direction wrong");
    chk_da_out: assert property (@(posedge clk) disable iff (!reset_n)
        analog_out_ch0_en |-> da_control[0] && !port9_bit3_oe
            && !port9_bit3_pullup && !timer_b3_mode[7])
        else $error("D-A output without its selects");
    chk_count_in: assert property (@(posedge clk) disable iff (!reset_n)
        ce && (mode4 == p9fs_pkg::PM_CNT_IN)
            |=> timer_b4_count_in == $past(pin_level[1]))
        else $error("timer B4 count input not following pin");
    chk_pu_group: assert property (@(posedge clk)
        disable iff (!reset_n)
        port9_bit5_pullup || port9_bit4_pullup |-> port_pullup_control[3])
        else $error("high nibble pull-up without its bit");
    chk_write_next: assert property (@(posedge clk)
        disable iff (!reset_n)
        do_write && wr_lane && (wr_idx == p9fs_pkg::DIR_IDX)
            |=> port9_direction == $past(wr_byte)
                && (port9_bit5_oe || !$past(wr_byte[5])))
        else $error("direction write not applied next clock");
endmodule // p9fs_pin_select

//--- verification/p9fs_board.sv
`timescale 1ns/1ps
// Board side of the three pins; index 0 is pin 3, index 2 is pin 5
module p9fs_board (
    input wire logic clk,
    input wire logic [2:0] oe,
    input wire logic [2:0] dout,
    input wire logic [2:0] pull_en,
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    output logic [2:0] pin
);
    logic [2:0] wobble = 3'h0;
    // Floating pin without pull-up keeps changing
    always @(posedge clk) begin
        wobble <= ~wobble;
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (oe[i])
                pin[i] = dout[i];
            else if (ext_en[i])
                pin[i] = ext_val[i];
            else if (pull_en[i])
                pin[i] = 1'h1;
            else
                pin[i] = wobble[i];
        end
    end
endmodule // p9fs_board

//--- verification/port9_upper_pin_function_select_test.sv
`timescale 1ns/1ps
module port9_upper_pin_function_select_test;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata;
    logic [7:0] last_data;
    logic [2:0] oe, dout, pu, pin;
    logic [2:0] ext_en = 3'h0, ext_val = 3'h0;
    logic sclk_drive = 1'h0;
    logic sclk, anex, opamp, da1, da0, tb4, tb3;
    int bad_count = 0, n_compared = 0, cycles = 0;

    always #20 clk = ~clk;

    p9fs_pin_select uut (.clk(clk), .reset_n(reset_n), .ce(1'h1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port9_bit5_in(pin[2]), .port9_bit5_out(dout[2]),
        .port9_bit5_oe(oe[2]), .port9_bit5_pullup(pu[2]),
        .port9_bit4_in(pin[1]), .port9_bit4_out(dout[1]),
        .port9_bit4_oe(oe[1]), .port9_bit4_pullup(pu[1]),
        .port9_bit3_in(pin[0]), .port9_bit3_out(dout[0]),
        .port9_bit3_oe(oe[0]), .port9_bit3_pullup(pu[0]),
        .serial_unit4_clock_drive(sclk_drive), .serial_unit4_clock(sclk),
        .analog_extension_in0_sel(anex), .opamp_out_en(opamp),
        .analog_out_ch1_en(da1), .analog_out_ch0_en(da0),
        .timer_b4_count_in(tb4), .timer_b3_count_in(tb3));

    p9fs_board board (.clk(clk), .oe(oe), .dout(dout), .pull_en(pu),
        .ext_en(ext_en), .ext_val(ext_val), .pin(pin));

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] val);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        @(posedge clk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, val};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'h0;
                aw_done = 1'h1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'h0;
                w_done = 1'h1;
            end
        end while (!(aw_done && w_done));
        do @(posedge clk); while (!bvalid);
        last_resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [9:0] idx);
        @(posedge clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        last_data = rdata[7:0];
        last_resp = rresp;
        rready <= 1'h0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic test_regs();
        rd(p9fs_pkg::DIR_IDX);
        check("dir reset", 8'h00, last_data);
        check("dir rresp", {6'h0, p9fs_pkg::RESP_OKAY}, {6'h0, last_resp});
        rd(10'h000);
        check("unmapped rresp", {6'h0, p9fs_pkg::RESP_SLVERR},
              {6'h0, last_resp});
        wr(10'h000, 8'hFF);
        check("unmapped bresp", {6'h0, p9fs_pkg::RESP_SLVERR},
              {6'h0, last_resp});
        $display("test regs done");
    endtask

    task automatic test_port_out();
        wr(p9fs_pkg::PU_IDX, 8'h0C);
        wr(p9fs_pkg::DATA_IDX, 8'h20);
        wr(p9fs_pkg::DIR_IDX, 8'h20);
        settle(3);
        check("out oe", 8'h04, {5'h0, oe});
        check("out level", 8'h04, {5'h0, dout});
        check("out pullups", 8'h03, {5'h0, pu});
        wr(p9fs_pkg::DATA_IDX, 8'h00);
        settle(3);
        check("out low", 8'h00, {5'h0, dout});
        wr(p9fs_pkg::DIR_IDX, 8'h00);
        $display("test port out done");
    endtask

    task automatic test_inputs();
        wr(p9fs_pkg::PU_IDX, 8'h08);
        settle(8);
        check("pull hi nibble", 8'h06, {5'h0, pu});
        rd(p9fs_pkg::STAT_IDX);
        check("pulled levels", 8'h06, last_data & 8'h3E);
        wr(p9fs_pkg::PU_IDX, 8'h04);
        settle(2);
        check("pull lo nibble", 8'h01, {5'h0, pu});
        wr(p9fs_pkg::PU_IDX, 8'h00);
        ext_en <= 3'h4;
        ext_val <= 3'h4;
        settle(8);
        check("plain pullups", 8'h00, {5'h0, pu});
        rd(p9fs_pkg::STAT_IDX);
        check("plain high", 8'h04, last_data & 8'h3C);
        ext_val <= 3'h0;
        settle(8);
        rd(p9fs_pkg::STAT_IDX);
        check("plain low", 8'h00, last_data & 8'h3C);
        $display("test inputs done");
    endtask

    task automatic test_analog();
        wr(p9fs_pkg::AD1_IDX, 8'h40);
        settle(2);
        check("ext sel", 8'h02, {6'h0, anex, opamp});
        check("ext oe", 8'h00, {5'h0, oe});
        wr(p9fs_pkg::AD1_IDX, 8'hC0);
        settle(2);
        check("opamp", 8'h01, {7'h0, opamp});
        wr(p9fs_pkg::AD1_IDX, 8'h80);
        settle(2);
        check("bad combo", 8'h00, {6'h0, anex, opamp});
        wr(p9fs_pkg::AD1_IDX, 8'h00);
        $display("test analog done");
    endtask

    task automatic test_serial();
        wr(p9fs_pkg::SIO4_IDX, 8'h48);
        sclk_drive <= 1'h1;
        settle(3);
        check("sclk out oe", 8'h04, {5'h0, oe});
        check("sclk out hi", 8'h04, {5'h0, dout});
        sclk_drive <= 1'h0;
        settle(3);
        check("sclk out lo", 8'h00, {5'h0, dout});
        wr(p9fs_pkg::SIO4_IDX, 8'h08);
        ext_val <= 3'h4;
        settle(8);
        check("sclk in oe", 8'h00, {5'h0, oe});
        check("sclk in hi", 8'h01, {7'h0, sclk});
        ext_val <= 3'h0;
        settle(8);
        check("sclk in lo", 8'h00, {7'h0, sclk});
        wr(p9fs_pkg::SIO4_IDX, 8'h00);
        $display("test serial done");
    endtask

    task automatic test_dac();
        ext_en <= 3'h3;
        ext_val <= 3'h3;
        wr(p9fs_pkg::DAC_IDX, 8'h03);
        settle(8);
        check("dac on", 8'h03, {6'h0, da1, da0});
        check("dac oe", 8'h00, {5'h0, oe});
        check("dac no cnt", 8'h00, {6'h0, tb4, tb3});
        wr(p9fs_pkg::DAC_IDX, 8'h00);
        settle(8);
        check("count both", 8'h03, {6'h0, tb4, tb3});
        ext_val <= 3'h0;
        settle(8);
        check("count low", 8'h00, {6'h0, tb4, tb3});
        ext_val <= 3'h3;
        settle(8);
        wr(p9fs_pkg::TB4_IDX, 8'h80);
        settle(8);
        check("evt b4", 8'h01, {6'h0, tb4, tb3});
        wr(p9fs_pkg::TB4_IDX, 8'h00);
        wr(p9fs_pkg::TB3_IDX, 8'h80);
        settle(8);
        check("evt b3", 8'h02, {6'h0, tb4, tb3});
        $display("test dac done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'h1;
        test_regs();
        test_port_out();
        test_inputs();
        test_analog();
        test_serial();
        test_dac();
        conclude();
    end
endmodule // port9_upper_pin_function_select_test
